// ===== rtl/crossbar_switch_defs.vh
`ifndef CROSSBAR_SWITCH_DEFS_VH
`define CROSSBAR_SWITCH_DEFS_VH

// Port counts and path widths
`define CBS_NUM_PORTS   6
`define CBS_IDX_W       3
`define CBS_ADDR_W      32
`define CBS_DATA_W      32

// Slave select field of the address
`define CBS_SEL_MSB     30
`define CBS_SEL_LSB     28

// Slave port that holds the program flash
`define CBS_FLASH_SLAVE 3'h0

// Priority field width; higher value wins
`define CBS_PRIO_W      3
`define CBS_PRIO_EQUAL  18'h00000

`endif

// ===== rtl/rr_priority_arbiter.v
`timescale 1ns/1ps
`include "crossbar_switch_defs.vh"

module rr_priority_arbiter #(
    parameter N    = `CBS_NUM_PORTS,
    parameter IW   = `CBS_IDX_W,
    parameter PW   = `CBS_PRIO_W,
    parameter PRIO = `CBS_PRIO_EQUAL
) (
    input  wire [N-1:0]  req,
    input  wire [IW-1:0] last,
    output reg  [IW-1:0] grant,
    output reg           grant_valid
);
    integer         i;
    integer         k;
    integer         idx;
    reg    [PW-1:0] top;

    always @* begin
        top         = {PW{1'b0}};
        grant       = {IW{1'b0}};
        grant_valid = 1'b0;
        idx         = 0;
        // Highest priority among the requesters
        for (i = 0; i < N; i = i + 1) begin
            if (req[i] && (PRIO[i*PW +: PW] > top)) begin
                top = PRIO[i*PW +: PW];
            end
        end
        // Walk down so the nearest master after the last grant wins
        for (k = N; k >= 1; k = k - 1) begin
            idx = (last + k) % N;
            if (req[idx] && (PRIO[idx*PW +: PW] == top)) begin
                grant       = idx[IW-1:0];
                grant_valid = 1'b1;
            end
        end
    end
endmodule // rr_priority_arbiter

// ===== rtl/crossbar_switch.v
`timescale 1ns/1ps
`include "crossbar_switch_defs.vh"

// Overview of operation
// - Six master ports reach six slave ports; separate pairs run concurrently.
// - Every port carries a 32-bit address path and a 32-bit data path.
// - A master may have two transactions open if one is a flash fetch.
// - Simultaneous requests for one slave go to the highest priority master.
// - Losing masters stall until the winner finishes on that slave port.
// - Equal priority masters are served round-robin after the last granted one.
module crossbar_switch #(
    parameter N    = `CBS_NUM_PORTS,
    parameter IW   = `CBS_IDX_W,
    parameter AW   = `CBS_ADDR_W,
    parameter DW   = `CBS_DATA_W,
    parameter PW   = `CBS_PRIO_W,
    parameter PRIO = `CBS_PRIO_EQUAL
) (
    input  wire           core_clk,
    input  wire           reset,
    input  wire           clk_en,
    // Master data lanes
    input  wire [N-1:0]    m_req,
    input  wire [N*AW-1:0] m_addr,
    input  wire [N-1:0]    m_write,
    input  wire [N*DW-1:0] m_wdata,
    output reg  [N-1:0]    m_done,
    output reg  [N-1:0]    m_err,
    output reg  [N*DW-1:0] m_rdata,
    output reg  [N-1:0]    m_stall,
    // Master instruction fetch lanes, flash only
    input  wire [N-1:0]    f_req,
    input  wire [N*AW-1:0] f_addr,
    output reg  [N-1:0]    f_done,
    output reg  [N*DW-1:0] f_rdata,
    output reg  [N-1:0]    f_stall,
    // Slave ports
    output reg  [N-1:0]    s_req,
    output reg  [N*AW-1:0] s_addr,
    output reg  [N-1:0]    s_write,
    output reg  [N*DW-1:0] s_wdata,
    input  wire [N-1:0]    s_done,
    input  wire [N*DW-1:0] s_rdata
);
    localparam [IW-1:0] FLASH = `CBS_FLASH_SLAVE;
    localparam          SW    = `CBS_SEL_MSB - `CBS_SEL_LSB + 1;

    reg  [N-1:0]   main_pend;
    reg  [N-1:0]   fetch_pend;
    wire [N-1:0]   main_cand;
    wire [N-1:0]   fetch_cand;
    wire [N-1:0]   main_unmapped;
    wire [N*N-1:0] gnt_main;
    wire [N*N-1:0] gnt_fetch;
    wire [N*N-1:0] cmp_main;
    wire [N*N-1:0] cmp_fetch;

    genvar m;
    genvar s;

    generate
        for (m = 0; m < N; m = m + 1) begin : g_master
            wire [SW-1:0] sel = m_addr[m*AW + `CBS_SEL_LSB +: SW];
            wire [N-1:0]  gm;
            wire [N-1:0]  gf;
            wire [N-1:0]  cm;
            wire [N-1:0]  cf;
            reg  [DW-1:0] next_rdata;
            reg  [DW-1:0] next_frdata;
            integer       j;

            // A finished request is not seen again in its done cycle
            assign main_cand[m]     = m_req[m] & ~main_pend[m] & ~m_done[m] & ~m_err[m];
            assign fetch_cand[m]    = f_req[m] & ~fetch_pend[m] & ~f_done[m];
            assign main_unmapped[m] = (sel >= N);

            for (s = 0; s < N; s = s + 1) begin : g_col
                assign gm[s] = gnt_main[s*N + m];
                assign gf[s] = gnt_fetch[s*N + m];
                assign cm[s] = cmp_main[s*N + m];
                assign cf[s] = cmp_fetch[s*N + m];
            end

            always @* begin
                next_rdata  = {DW{1'b0}};
                next_frdata = {DW{1'b0}};
                for (j = 0; j < N; j = j + 1) begin
                    if (cm[j]) begin
                        next_rdata = s_rdata[j*DW +: DW];
                    end
                    if (cf[j]) begin
                        next_frdata = s_rdata[j*DW +: DW];
                    end
                end
            end

            always @(posedge core_clk) begin
                if (reset) begin
                    main_pend[m]           <= 1'b0;
                    fetch_pend[m]          <= 1'b0;
                    m_done[m]              <= 1'b0;
                    m_err[m]               <= 1'b0;
                    m_stall[m]             <= 1'b0;
                    f_done[m]              <= 1'b0;
                    f_stall[m]             <= 1'b0;
                    m_rdata[m*DW +: DW]    <= {DW{1'b0}};
                    f_rdata[m*DW +: DW]    <= {DW{1'b0}};
                end else if (clk_en) begin
                    // Data and fetch lanes run independently
                    main_pend[m]  <= (main_pend[m] | (|gm)) & ~(|cm);
                    fetch_pend[m] <= (fetch_pend[m] | (|gf)) & ~(|cf);
                    m_done[m]     <= |cm;
                    f_done[m]     <= |cf;
                    // Unmapped slave select answers at once with an error
                    m_err[m]      <= main_cand[m] & main_unmapped[m];
                    // Requesters without a grant wait
                    m_stall[m]    <= main_cand[m] & ~main_unmapped[m] & ~(|gm);
                    f_stall[m]    <= fetch_cand[m] & ~(|gf);
                    if (|cm) begin
                        m_rdata[m*DW +: DW] <= next_rdata;
                    end
                    if (|cf) begin
                        f_rdata[m*DW +: DW] <= next_frdata;
                    end
                end
            end
        end

        // One arbiter and one owner per slave port
        for (s = 0; s < N; s = s + 1) begin : g_slave
            reg           busy;
            reg           own_fetch;
            reg  [IW-1:0] owner;
            reg  [IW-1:0] last;
            wire [N-1:0]  want_main;
            wire [N-1:0]  want_fetch;
            wire [N-1:0]  want;
            wire [IW-1:0] pick;
            wire          pick_valid;
            wire          take;
            wire          lane;

            for (m = 0; m < N; m = m + 1) begin : g_row
                assign want_main[m]  = main_cand[m] & ~main_unmapped[m]
                                     & (m_addr[m*AW + `CBS_SEL_LSB +: SW] == s);
                // Only the flash port accepts the fetch lane
                assign want_fetch[m] = fetch_cand[m] & (FLASH == s);
                assign want[m]       = want_main[m] | want_fetch[m];
                assign gnt_main[s*N + m]  = take & ~lane & (pick == m);
                assign gnt_fetch[s*N + m] = take & lane & (pick == m);
                assign cmp_main[s*N + m]  = busy & s_done[s] & ~own_fetch & (owner == m);
                assign cmp_fetch[s*N + m] = busy & s_done[s] & own_fetch & (owner == m);
            end

            rr_priority_arbiter #(
                .N    (N),
                .IW   (IW),
                .PW   (PW),
                .PRIO (PRIO)
            ) u_arb (
                .req         (want),
                .last        (last),
                .grant       (pick),
                .grant_valid (pick_valid)
            );

            // Only a free port grants; the owner keeps it until done
            assign take = ~busy & pick_valid;
            // Fetch goes first when one master wants flash on both lanes
            assign lane = want_fetch[pick];

            always @(posedge core_clk) begin
                if (reset) begin
                    busy                <= 1'b0;
                    own_fetch           <= 1'b0;
                    owner               <= {IW{1'b0}};
                    last                <= {IW{1'b0}};
                    s_req[s]            <= 1'b0;
                    s_write[s]          <= 1'b0;
                    s_addr[s*AW +: AW]  <= {AW{1'b0}};
                    s_wdata[s*DW +: DW] <= {DW{1'b0}};
                end else if (clk_en) begin
                    if (take) begin
                        busy      <= 1'b1;
                        owner     <= pick;
                        own_fetch <= lane;
                        last      <= pick;
                        s_req[s]  <= 1'b1;
                        // Full 32-bit paths routed through
                        if (lane) begin
                            s_addr[s*AW +: AW]  <= f_addr[pick*AW +: AW];
                            s_write[s]          <= 1'b0;
                            s_wdata[s*DW +: DW] <= {DW{1'b0}};
                        end else begin
                            s_addr[s*AW +: AW]  <= m_addr[pick*AW +: AW];
                            s_write[s]          <= m_write[pick];
                            s_wdata[s*DW +: DW] <= m_wdata[pick*DW +: DW];
                        end
                    end else if (busy && s_done[s]) begin
                        // Release only on completion
                        busy     <= 1'b0;
                        s_req[s] <= 1'b0;
                    end
                end
            end
        end
    endgenerate
endmodule // crossbar_switch

// ===== testbench/crossbar_switch_sva.sv
`timescale 1ns/1ps
module crossbar_switch_chk (
    input wire         core_clk,
    input wire         reset,
    input wire [5:0]   m_req,
    input wire [191:0] m_addr,
    input wire [5:0]   m_done,
    input wire [5:0]   m_err,
    input wire [5:0]   m_stall,
    input wire [5:0]   f_req,
    input wire [5:0]   f_done,
    input wire [5:0]   s_req,
    input wire [191:0] s_addr,
    input wire [5:0]   s_done
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    property p_src; $rose(s_req[3]) |-> $past(m_req | f_req) != 0; endproperty
    a_src: assert property (p_src) else $error("slave request without master");
    property p_hold; s_req[2] && !s_done[2] |=> s_req[2]; endproperty
    a_hold: assert property (p_hold) else $error("grant dropped early");
    property p_stbl; s_req[1] && !$rose(s_req[1]) |-> $stable(s_addr[63:32]); endproperty
    a_stbl: assert property (p_stbl) else $error("slave address moved");
    property p_done; s_done[3] |=> (m_done | f_done) != 0; endproperty
    a_done: assert property (p_done) else $error("completion not returned");
    property p_stall; (m_stall & ~$past(m_req)) == 0; endproperty
    a_stall: assert property (p_stall) else $error("stall without request");
    property p_err; m_err[0] |-> $past(m_req[0]) && $past(m_addr[30:29]) == 2'b11; endproperty
    a_err: assert property (p_err) else $error("bad error pulse");
    property p_flash; f_done != 0 |-> $past(s_done[0]); endproperty
    a_flash: assert property (p_flash) else $error("fetch not from flash");
    property p_pulse; m_done[1] |=> !m_done[1]; endproperty
    a_pulse: assert property (p_pulse) else $error("done longer than one cycle");
endmodule // crossbar_switch_chk

// ===== testbench/slave_model.sv
`timescale 1ns/1ps
module slave_model (
    input  wire         core_clk,
    input  wire [5:0]   s_req,
    input  wire [191:0] s_addr,
    input  wire [5:0]   s_write,
    input  wire [191:0] s_wdata,
    output reg  [5:0]   s_done,
    output reg  [191:0] s_rdata
);
    integer k;
    integer seed = 911;
    reg     go;
    initial s_done = 0;
    initial s_rdata = 0;
    // Random wait so both quick and slow answers occur
    always @(posedge core_clk) begin
        for (k = 0; k < 6; k = k + 1) begin
            go = s_req[k] && !s_done[k] && ($random(seed) & 1);
            s_done[k] <= go;
            // Data toggles outside the answer cycle; writes echo their data so the write path is seen
            s_rdata[k*32+:32] <= !go ? ~s_rdata[k*32+:32] :
                                 s_write[k] ? s_wdata[k*32+:32] : ~{s_addr[k*32+:28], 1'b0, k[2:0]};
        end
    end
endmodule // slave_model

// ===== testbench/crossbar_switch_tb_top.sv
`timescale 1ns/1ps
module crossbar_switch_tb_top;
    reg          core_clk = 0;
    reg          reset = 1;
    reg          clk_en = 1;
    reg  [5:0]   m_req = 0;
    reg  [191:0] m_addr = 0;
    reg  [5:0]   m_write = 0;
    reg  [191:0] m_wdata = 0;
    reg  [5:0]   f_req = 0;
    reg  [191:0] f_addr = 0;
    wire [5:0]   m_done, m_err, m_stall, f_done, f_stall, s_req, s_write, s_done;
    wire [191:0] m_rdata, f_rdata, s_addr, s_wdata, s_rdata;
    integer      err_total = 0;
    integer      comparisons = 0;
    integer      seed = 73559;
    integer      i, k, nxt;
    always #50 core_clk = ~core_clk;
    crossbar_switch uut (
        .core_clk (core_clk),
        .reset    (reset),
        .clk_en   (clk_en),
        .m_req    (m_req),
        .m_addr   (m_addr),
        .m_write  (m_write),
        .m_wdata  (m_wdata),
        .m_done   (m_done),
        .m_err    (m_err),
        .m_rdata  (m_rdata),
        .m_stall  (m_stall),
        .f_req    (f_req),
        .f_addr   (f_addr),
        .f_done   (f_done),
        .f_rdata  (f_rdata),
        .f_stall  (f_stall),
        .s_req    (s_req),
        .s_addr   (s_addr),
        .s_write  (s_write),
        .s_wdata  (s_wdata),
        .s_done   (s_done),
        .s_rdata  (s_rdata)
    );
    slave_model far_end (
        .core_clk (core_clk),
        .s_req    (s_req),
        .s_addr   (s_addr),
        .s_write  (s_write),
        .s_wdata  (s_wdata),
        .s_done   (s_done),
        .s_rdata  (s_rdata)
    );
    function [31:0] exp_rd(input [31:0] a, input f);
        exp_rd = ~{a[27:0], 1'b0, f ? 3'h0 : a[30:28]};
    endfunction
    // Writes come back as the written word, reads as the address pattern
    function [31:0] exp_m(input integer j);
        exp_m = m_write[j] ? m_wdata[j*32+:32] : exp_rd(m_addr[j*32+:32], 1'b0);
    endfunction
    task chk(input ok);
        begin
            comparisons = comparisons + 1;
            if (ok !== 1'b1) begin
                err_total = err_total + 1;
                $display("wrong value at %0t: port mismatch", $time);
            end
        end
    endtask
    task finish_test;
        begin
            $display("errors %0d of %0d checks", err_total, comparisons);
            if (err_total == 0 && comparisons > 0) $display("All checks passed");
            else $display("Checks failed");
            $finish;
        end
    endtask
    task setup(input rr);
        begin
            for (i = 0; i < 6; i = i + 1) begin
                m_addr[i*32+:32] = $random(seed);
                m_addr[i*32+31] = 1'b0;
                if (rr) m_addr[i*32+28+:3] = 3'h3;
                f_addr[i*32+:32] = $random(seed);
                m_wdata[i*32+:32] = $random(seed);
            end
            m_write = $random(seed);
        end
    endtask
    // Requests held until done, then dropped before the next edge
    task burst(input [5:0] mk, input [5:0] fm, input rr, input ff);
        integer n;
        begin
            n = 0;
            nxt = 1;
            m_req = mk;
            f_req = fm;
            while ((m_req | f_req) != 0 && n < 300) begin
                @(negedge core_clk);
                n = n + 1;
                if (rr && n == 2) chk(m_stall === 6'h3d);
                if (ff && n == 2) chk(f_stall === 6'h3d);
                for (k = 0; k < 6; k = k + 1) begin
                    if (m_req[k] && (m_done[k] || m_err[k])) begin
                        chk(m_err[k] === (m_addr[k*32+29+:2] == 2'b11));
                        if (m_done[k]) chk(m_rdata[k*32+:32] === exp_m(k));
                        if (rr) chk(k == nxt);
                        nxt = (k + 1) % 6;
                        m_req[k] = 1'b0;
                    end
                    if (f_req[k] && f_done[k]) begin
                        chk(f_rdata[k*32+:32] === exp_rd(f_addr[k*32+:32], 1));
                        f_req[k] = 1'b0;
                    end
                end
            end
            chk(n < 300);
        end
    endtask
    initial begin
        fork
            begin
                repeat (20000) @(posedge core_clk);
                err_total = err_total + 1;
                finish_test;
            end
        join_none
        repeat (10) @(posedge core_clk);
        @(negedge core_clk);
        reset = 0;
        @(negedge core_clk);
        setup(1);
        burst(6'h3f, 6'h00, 1, 0);
        // Frozen clock enable: nothing granted, nothing stalled
        @(negedge core_clk);
        clk_en = 0;
        m_req = 6'h3f;
        repeat (3) @(negedge core_clk);
        chk(s_req === 6'h00 && m_stall === 6'h00 && m_done === 6'h00);
        clk_en = 1;
        burst(6'h3f, 6'h00, 1, 0);
        @(negedge core_clk);
        setup(0);
        burst(6'h3f, 6'h3f, 0, 1);
        repeat (40) begin
            @(negedge core_clk);
            setup(0);
            burst($random(seed), $random(seed), 0, 0);
        end
        finish_test;
    end
endmodule // crossbar_switch_tb_top
bind crossbar_switch crossbar_switch_chk chk_i (
    .core_clk (core_clk),
    .reset    (reset),
    .m_req    (m_req),
    .m_addr   (m_addr),
    .m_done   (m_done),
    .m_err    (m_err),
    .m_stall  (m_stall),
    .f_req    (f_req),
    .f_done   (f_done),
    .s_req    (s_req),
    .s_addr   (s_addr),
    .s_done   (s_done)
);
